// File: lmfe_top.sv
// lin master frame engine: apb registers, mode control, header and response handling
//
// Decided for this implementation: the APB slave port and the register addresses.
`timescale 1ns/1ns

// What this block does
// (RQ1) bus level 0 is dominant, 1 is recessive; idle output stays 1.
// (RQ2) every frame opens with 13 dominant bit times then one recessive delimiter.
// (RQ3) the break is followed by a sync byte of value 0x55.
// (RQ4) header order is break, sync, protected identifier; a slave task answers.
// (RQ5) each byte: dominant start, eight data bits lsb first, recessive stop.
// (RQ6) identifier byte holds six id bits low and two parity bits high.
// (RQ7) parity zero is xor of id 0,1,2,4; parity one inverts xor of 1,3,4,5.
// (RQ8) checksum is the inverted eight bit sum with carries added back.
// (RQ9) classic sums data only; enhanced adds the identifier; picked per message.
// (RQ10) after reset the controller sits in sleep mode.
// (RQ11) init request bit enters or leaves init; sleep request bit enters sleep.
// (RQ12) init mode halts transfers, drives output recessive, keeps configuration.
// (RQ13) software configures mode and baud during init, then clears init.
// (RQ14) sleep stops the engine and every status update but the wake flag; registers stay accessible.
// (RQ15) with auto wake, a 150 us dominant pulse clears the sleep request.
// (RQ16) master select set makes the block a master using its one buffer.
// (RQ17) software loads identifier, length, direction, checksum type before header request.
// (RQ18) publisher data sent after header, length bytes then checksum.
// (RQ19) direction set means publish; clear means receive the response.
// (RQ20) received bytes go to the buffer; outcome is recorded in status.
// (RQ21) after a header request the frame runs to its end without software.
// (RQ22) master select clear means slave operation, so no headers are sent.
// (RQ23) bit period comes from the baud divider, written only in init mode.
module lmfe_top (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // lin transceiver
  input wire logic lin_rx,
  output logic bus_transmit_output
);

  // control registers
  logic init_req_q;
  logic sleep_req_q;
  logic auto_wake_enable_q;
  logic master_select_q;
  logic header_send_request_q;
  logic [15:0] baud_div_q;
  logic [5:0] frame_id_q;
  logic dir_q;
  logic checksum_type_select_q;
  logic [2:0] payload_length_field_q;
  logic [7:0] buf_q [0:7];
  logic [lmfe_pkg::NUM_FLAGS-1:0] flags_q;
  logic [31:0] prdata_q;

  // engine and wake counter
  lmfe_pkg::lmfe_state_e st_q;
  lmfe_pkg::lmfe_field_e fld_q;
  logic [15:0] bit_cnt_q;
  logic [3:0] nbits_q;
  logic [9:0] tx_shift_q;
  logic [9:0] rx_shift_q;
  logic [2:0] idx_q;
  logic [7:0] csum_q;
  logic txd_q;
  logic [11:0] wake_cnt_q;

  // one-cycle events from the engine and the wake detector
  logic ev_tx_done_q;
  logic ev_rx_done_q;
  logic ev_cs_err_q;
  logic ev_fr_err_q;
  logic ev_wake_q;
  logic rx_wr_q;
  logic [2:0] rx_wr_idx_q;
  logic [7:0] rx_wr_byte_q;

  lmfe_pkg::lmfe_mode_e mode;
  logic apb_wr;
  logic apb_setup_rd;
  logic tick;
  logic hdr_take;
  logic [7:0] pid;
  logic [7:0] rx_byte;
  logic [lmfe_pkg::NUM_FLAGS-1:0] flag_set;

  function automatic logic [7:0] csum_add(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    s = {1'b0, a} + {1'b0, b};
    csum_add = s[7:0] + {7'h00, s[8]}; // RQ8
  endfunction : csum_add

  function automatic logic [9:0] frame_char(input logic [7:0] b);
    frame_char = {1'b1, b, 1'b0}; // RQ5
  endfunction : frame_char

  // sleep wins over init so a sleep request always stops the engine
  always_comb begin
    if (sleep_req_q) begin
      mode = lmfe_pkg::MODE_SLEEP; // RQ14
    end else if (init_req_q) begin
      mode = lmfe_pkg::MODE_INIT; // RQ11
    end else begin
      mode = lmfe_pkg::MODE_NORMAL;
    end
  end

  assign pid = {~(frame_id_q[1] ^ frame_id_q[3] ^ frame_id_q[4] ^ frame_id_q[5]),
                frame_id_q[0] ^ frame_id_q[1] ^ frame_id_q[2] ^ frame_id_q[4],
                frame_id_q}; // RQ6 RQ7
  assign rx_byte = rx_shift_q[9:2];
  assign tick = (bit_cnt_q == 16'h0000); // RQ23
  assign hdr_take = (st_q == lmfe_pkg::ENG_IDLE) && (mode == lmfe_pkg::MODE_NORMAL) &&
                    master_select_q && header_send_request_q; // RQ16 RQ22

  // apb: zero wait states, read data captured in the setup cycle
  assign pready = 1'b1;
  assign apb_wr = psel && penable && pwrite;
  assign apb_setup_rd = psel && !penable && !pwrite;
  assign prdata = prdata_q;
  assign pslverr = psel && penable && !((paddr == lmfe_pkg::OFS_CONTROL_ONE) ||
                   (paddr == lmfe_pkg::OFS_CONTROL_TWO) || (paddr == lmfe_pkg::OFS_BAUD) ||
                   (paddr == lmfe_pkg::OFS_BUF_ID) || (paddr == lmfe_pkg::OFS_PAYLOAD_LO) ||
                   (paddr == lmfe_pkg::OFS_PAYLOAD_HI) || (paddr == lmfe_pkg::OFS_STATUS));
  assign bus_transmit_output = txd_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      prdata_q <= 32'h00000000;
    end else if (apb_setup_rd) begin
      if (paddr == lmfe_pkg::OFS_CONTROL_ONE) begin
        prdata_q <= {28'h0000000, master_select_q, auto_wake_enable_q, sleep_req_q, init_req_q};
      end else if (paddr == lmfe_pkg::OFS_CONTROL_TWO) begin
        prdata_q <= {31'h00000000, header_send_request_q};
      end else if (paddr == lmfe_pkg::OFS_BAUD) begin
        prdata_q <= {16'h0000, baud_div_q};
      end else if (paddr == lmfe_pkg::OFS_BUF_ID) begin
        prdata_q <= {19'h00000, payload_length_field_q, checksum_type_select_q, dir_q,
                     2'h0, frame_id_q};
      end else if (paddr == lmfe_pkg::OFS_PAYLOAD_LO) begin
        prdata_q <= {buf_q[3], buf_q[2], buf_q[1], buf_q[0]};
      end else if (paddr == lmfe_pkg::OFS_PAYLOAD_HI) begin
        prdata_q <= {buf_q[7], buf_q[6], buf_q[5], buf_q[4]};
      end else if (paddr == lmfe_pkg::OFS_STATUS) begin
        prdata_q <= {20'h00000, mode, header_send_request_q, st_q != lmfe_pkg::ENG_IDLE,
                     3'h0, flags_q};
      end else begin
        prdata_q <= 32'h00000000;
      end
    end
  end

  // control_reg_one; hardware wake clears sleep unless software writes the same cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      init_req_q <= lmfe_pkg::CR1_INIT_RST;
      sleep_req_q <= lmfe_pkg::CR1_SLEEP_RST; // RQ10
      auto_wake_enable_q <= lmfe_pkg::CR1_AWAKE_RST;
      master_select_q <= lmfe_pkg::CR1_MASTER_RST;
    end else if (apb_wr && paddr == lmfe_pkg::OFS_CONTROL_ONE) begin
      init_req_q <= pwdata[lmfe_pkg::CR1_INIT_BIT]; // RQ11
      sleep_req_q <= pwdata[lmfe_pkg::CR1_SLEEP_BIT]; // RQ11
      auto_wake_enable_q <= pwdata[lmfe_pkg::CR1_AWAKE_BIT];
      master_select_q <= pwdata[lmfe_pkg::CR1_MASTER_BIT]; // RQ16
    end else if (ev_wake_q && auto_wake_enable_q) begin
      sleep_req_q <= 1'b0; // RQ15
    end
  end

  // header request: a new write wins over the engine taking the old one
  always_ff @(posedge clk) begin
    if (srst) begin
      header_send_request_q <= 1'b0;
    end else if (apb_wr && paddr == lmfe_pkg::OFS_CONTROL_TWO &&
                 pwdata[lmfe_pkg::CR2_HDR_BIT]) begin
      header_send_request_q <= 1'b1; // RQ17
    end else if (hdr_take) begin
      header_send_request_q <= 1'b0;
    end
  end

  // changing the bit period mid-frame would corrupt the frame, so only init may write it
  always_ff @(posedge clk) begin
    if (srst) begin
      baud_div_q <= lmfe_pkg::BAUD_DIV_RST;
    end else if (apb_wr && paddr == lmfe_pkg::OFS_BAUD && mode == lmfe_pkg::MODE_INIT) begin
      baud_div_q <= pwdata[15:0]; // RQ23
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      frame_id_q <= lmfe_pkg::BID_ID_RST;
      dir_q <= 1'b0;
      checksum_type_select_q <= 1'b0;
      payload_length_field_q <= lmfe_pkg::BID_DFL_RST;
    end else if (apb_wr && paddr == lmfe_pkg::OFS_BUF_ID) begin
      frame_id_q <= pwdata[lmfe_pkg::BID_ID_LSB +: 6]; // RQ17
      dir_q <= pwdata[lmfe_pkg::BID_DIR_BIT]; // RQ19
      checksum_type_select_q <= pwdata[lmfe_pkg::BID_CCS_BIT]; // RQ9
      payload_length_field_q <= pwdata[lmfe_pkg::BID_DFL_LSB +: 3];
    end
  end

  // message buffer: software words and received bytes share one array
  always_ff @(posedge clk) begin
    if (srst) begin
      for (int i = 0; i < 8; i++) begin
        buf_q[i] <= 8'h00;
      end
    end else if (rx_wr_q) begin
      buf_q[rx_wr_idx_q] <= rx_wr_byte_q; // RQ20
    end else if (apb_wr && paddr == lmfe_pkg::OFS_PAYLOAD_LO) begin
      for (int i = 0; i < 4; i++) begin
        buf_q[i] <= pwdata[8*i +: 8]; // RQ18
      end
    end else if (apb_wr && paddr == lmfe_pkg::OFS_PAYLOAD_HI) begin
      for (int i = 0; i < 4; i++) begin
        buf_q[i+4] <= pwdata[8*i +: 8];
      end
    end
  end

  // sticky status flags, write one to clear; a set in the clearing cycle wins
  assign flag_set = {ev_wake_q, ev_fr_err_q, ev_cs_err_q, ev_rx_done_q, ev_tx_done_q};

  generate
    for (genvar g = 0; g < lmfe_pkg::NUM_FLAGS; g++) begin : g_flag
      always_ff @(posedge clk) begin
        if (srst) begin
          flags_q[g] <= 1'b0;
        end else if (flag_set[g]) begin
          flags_q[g] <= 1'b1; // RQ20
        end else if (apb_wr && paddr == lmfe_pkg::OFS_STATUS && pwdata[g]) begin
          flags_q[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // wake detector: counts consecutive dominant cycles while asleep
  always_ff @(posedge clk) begin
    if (srst) begin
      wake_cnt_q <= 12'h000;
      ev_wake_q <= 1'b0;
    end else begin
      ev_wake_q <= 1'b0;
      if (mode != lmfe_pkg::MODE_SLEEP || lin_rx) begin
        wake_cnt_q <= 12'h000;
      end else if (wake_cnt_q == 12'(lmfe_pkg::WAKE_CYCLES - 1)) begin
        wake_cnt_q <= 12'h000;
        ev_wake_q <= 1'b1; // RQ15
      end else begin
        wake_cnt_q <= wake_cnt_q + 12'h001;
      end
    end
  end

  // bit timer; reloads from the divider each bit, restarts half way on a start edge
  always_ff @(posedge clk) begin
    if (srst) begin
      bit_cnt_q <= 16'h0000;
    end else if (hdr_take) begin
      bit_cnt_q <= baud_div_q - 16'h0001; // RQ23
    end else if (st_q == lmfe_pkg::ENG_RX_WAIT) begin
      bit_cnt_q <= {1'b0, baud_div_q[15:1]};
    end else if (st_q == lmfe_pkg::ENG_IDLE || tick) begin
      bit_cnt_q <= baud_div_q - 16'h0001;
    end else begin
      bit_cnt_q <= bit_cnt_q - 16'h0001;
    end
  end

  // frame engine
  always_ff @(posedge clk) begin
    if (srst) begin
      st_q <= lmfe_pkg::ENG_IDLE;
      fld_q <= lmfe_pkg::FLD_SYNC;
      nbits_q <= 4'h0;
      tx_shift_q <= 10'h3FF;
      rx_shift_q <= 10'h000;
      idx_q <= 3'h0;
      csum_q <= 8'h00;
      txd_q <= 1'b1; // RQ1
      ev_tx_done_q <= 1'b0;
      ev_rx_done_q <= 1'b0;
      ev_cs_err_q <= 1'b0;
      ev_fr_err_q <= 1'b0;
      rx_wr_q <= 1'b0;
      rx_wr_idx_q <= 3'h0;
      rx_wr_byte_q <= 8'h00;
    end else begin
      ev_tx_done_q <= 1'b0;
      ev_rx_done_q <= 1'b0;
      ev_cs_err_q <= 1'b0;
      ev_fr_err_q <= 1'b0;
      rx_wr_q <= 1'b0;
      if (mode != lmfe_pkg::MODE_NORMAL) begin
        st_q <= lmfe_pkg::ENG_IDLE; // RQ12 RQ14
        txd_q <= 1'b1; // RQ12
      end else begin
        case (st_q)
          lmfe_pkg::ENG_IDLE: begin
            txd_q <= 1'b1;
            if (hdr_take) begin
              st_q <= lmfe_pkg::ENG_BREAK; // RQ4 RQ21
              nbits_q <= 4'(lmfe_pkg::BREAK_BITS - 1);
              txd_q <= 1'b0; // RQ2
            end
          end
          lmfe_pkg::ENG_BREAK: begin
            if (tick) begin
              if (nbits_q == 4'h0) begin
                st_q <= lmfe_pkg::ENG_DELIM;
                nbits_q <= 4'(lmfe_pkg::DELIM_BITS - 1);
                txd_q <= 1'b1; // RQ2
              end else begin
                nbits_q <= nbits_q - 4'h1;
              end
            end
          end
          lmfe_pkg::ENG_DELIM: begin
            if (tick) begin
              if (nbits_q == 4'h0) begin
                st_q <= lmfe_pkg::ENG_TX;
                fld_q <= lmfe_pkg::FLD_SYNC;
                tx_shift_q <= frame_char(lmfe_pkg::SYNC_BYTE); // RQ3
                nbits_q <= 4'h9;
                txd_q <= 1'b0;
              end else begin
                nbits_q <= nbits_q - 4'h1;
              end
            end
          end
          lmfe_pkg::ENG_TX: begin
            if (tick) begin
              if (nbits_q != 4'h0) begin
                tx_shift_q <= {1'b1, tx_shift_q[9:1]}; // RQ5
                txd_q <= tx_shift_q[1];
                nbits_q <= nbits_q - 4'h1;
              end else begin
                nbits_q <= 4'h9;
                txd_q <= 1'b0;
                case (fld_q)
                  lmfe_pkg::FLD_SYNC: begin
                    fld_q <= lmfe_pkg::FLD_PID; // RQ4
                    tx_shift_q <= frame_char(pid);
                  end
                  lmfe_pkg::FLD_PID: begin
                    idx_q <= 3'h0;
                    if (dir_q) begin
                      fld_q <= lmfe_pkg::FLD_DATA; // RQ19
                      tx_shift_q <= frame_char(buf_q[0]); // RQ18
                      csum_q <= csum_add(checksum_type_select_q ? pid : 8'h00, buf_q[0]); // RQ9
                    end else begin
                      st_q <= lmfe_pkg::ENG_RX_WAIT; // RQ19
                      fld_q <= lmfe_pkg::FLD_DATA;
                      csum_q <= checksum_type_select_q ? pid : 8'h00; // RQ9
                      txd_q <= 1'b1;
                    end
                  end
                  lmfe_pkg::FLD_DATA: begin
                    if (idx_q == payload_length_field_q) begin
                      fld_q <= lmfe_pkg::FLD_CSUM;
                      tx_shift_q <= frame_char(~csum_q); // RQ8 RQ18
                    end else begin
                      idx_q <= idx_q + 3'h1;
                      tx_shift_q <= frame_char(buf_q[idx_q + 3'h1]);
                      csum_q <= csum_add(csum_q, buf_q[idx_q + 3'h1]);
                    end
                  end
                  default: begin
                    st_q <= lmfe_pkg::ENG_IDLE;
                    txd_q <= 1'b1;
                    ev_tx_done_q <= 1'b1; // RQ21
                  end
                endcase
              end
            end
          end
          lmfe_pkg::ENG_RX_WAIT: begin
            txd_q <= 1'b1;
            if (!lin_rx) begin
              st_q <= lmfe_pkg::ENG_RX; // RQ5
              nbits_q <= 4'h9;
            end
          end
          lmfe_pkg::ENG_RX: begin
            if (tick) begin
              rx_shift_q <= {lin_rx, rx_shift_q[9:1]};
              if (nbits_q != 4'h0) begin
                nbits_q <= nbits_q - 4'h1;
              end else if (!lin_rx) begin
                st_q <= lmfe_pkg::ENG_IDLE; // a dominant stop bit drops the frame
                ev_fr_err_q <= 1'b1;
              end else if (fld_q == lmfe_pkg::FLD_DATA) begin
                st_q <= lmfe_pkg::ENG_RX_WAIT;
                rx_wr_q <= 1'b1; // RQ20
                rx_wr_idx_q <= idx_q;
                rx_wr_byte_q <= rx_byte;
                csum_q <= csum_add(csum_q, rx_byte);
                if (idx_q == payload_length_field_q) begin
                  fld_q <= lmfe_pkg::FLD_CSUM;
                end else begin
                  idx_q <= idx_q + 3'h1;
                end
              end else begin
                st_q <= lmfe_pkg::ENG_IDLE;
                if (csum_add(csum_q, rx_byte) == lmfe_pkg::CSUM_GOOD) begin
                  ev_rx_done_q <= 1'b1; // RQ20 RQ21
                end else begin
                  ev_cs_err_q <= 1'b1; // RQ8 RQ20
                end
              end
            end
          end
          default: begin
            st_q <= lmfe_pkg::ENG_IDLE;
          end
        endcase
      end
    end
  end

endmodule : lmfe_top

// File: lmfe_pkg.sv
// constants, register map and types for the lin master frame engine
package lmfe_pkg;

  // clock and timing
  localparam int CLK_HZ = 25_000_000;
  localparam int WAKE_PULSE_US = 150;
  localparam int WAKE_CYCLES = (WAKE_PULSE_US * (CLK_HZ / 1_000_000) + 0);
  localparam int BREAK_BITS = 13;
  localparam int DELIM_BITS = 1;
  localparam logic [7:0] SYNC_BYTE = 8'h55;
  localparam logic [7:0] CSUM_GOOD = 8'hFF;

  // register byte offsets on the apb
  localparam logic [7:0] OFS_CONTROL_ONE = 8'h00;
  localparam logic [7:0] OFS_CONTROL_TWO = 8'h04;
  localparam logic [7:0] OFS_BAUD = 8'h08;
  localparam logic [7:0] OFS_BUF_ID = 8'h0C;
  localparam logic [7:0] OFS_PAYLOAD_LO = 8'h10;
  localparam logic [7:0] OFS_PAYLOAD_HI = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;

  // control_reg_one fields
  localparam int CR1_INIT_BIT = 0;
  localparam int CR1_SLEEP_BIT = 1;
  localparam int CR1_AWAKE_BIT = 2;
  localparam int CR1_MASTER_BIT = 3;
  localparam logic CR1_INIT_RST = 1'b0;
  localparam logic CR1_SLEEP_RST = 1'b1;
  localparam logic CR1_AWAKE_RST = 1'b0;
  localparam logic CR1_MASTER_RST = 1'b0;

  // control_reg_two fields
  localparam int CR2_HDR_BIT = 0;

  // baud divider: clk cycles per bus bit
  localparam logic [15:0] BAUD_DIV_RST = 16'h0516;

  // buffer_identifier_reg fields
  localparam int BID_ID_LSB = 0;
  localparam int BID_DIR_BIT = 8;
  localparam int BID_CCS_BIT = 9;
  localparam int BID_DFL_LSB = 10;
  localparam logic [5:0] BID_ID_RST = 6'h00;
  localparam logic [2:0] BID_DFL_RST = 3'h0;

  // line_status_reg fields
  localparam int ST_TXDONE_BIT = 0;
  localparam int ST_RXDONE_BIT = 1;
  localparam int ST_CSERR_BIT = 2;
  localparam int ST_FRERR_BIT = 3;
  localparam int ST_WAKE_BIT = 4;
  localparam int ST_BUSY_BIT = 8;
  localparam int ST_HDRPEND_BIT = 9;
  localparam int ST_MODE_LSB = 10;
  localparam int NUM_FLAGS = 5;

  typedef enum logic [1:0] {MODE_SLEEP, MODE_INIT, MODE_NORMAL} lmfe_mode_e;
  typedef enum logic [2:0] {
    ENG_IDLE, ENG_BREAK, ENG_DELIM, ENG_TX, ENG_RX_WAIT, ENG_RX
  } lmfe_state_e;
  typedef enum logic [1:0] {FLD_SYNC, FLD_PID, FLD_DATA, FLD_CSUM} lmfe_field_e;

endpackage : lmfe_pkg

// File: lmfe_sva.sv
// port assertions for the lin master frame engine
`timescale 1ns/1ns
module lmfe_sva (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // lin
  input wire logic lin_rx,
  input wire logic bus_transmit_output
);
  logic [31:0] lo_q, hi_q, div;
  logic [15:0] div_q;
  logic [1:0] cr_q;
  logic brk_q, syn_q, tx, wr;
  assign tx = bus_transmit_output;
  assign div = {16'h0000, div_q};
  assign wr = psel && penable && pwrite;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // divider mirror follows the design's rule that it only changes in init mode
  always_ff @(posedge clk) begin
    if (srst) begin
      cr_q <= 2'h2;
      div_q <= lmfe_pkg::BAUD_DIV_RST;
    end else if (wr && paddr == lmfe_pkg::OFS_CONTROL_ONE) begin
      cr_q <= pwdata[1:0];
    end else if (wr && paddr == lmfe_pkg::OFS_BAUD && cr_q == 2'h1) begin
      div_q <= pwdata[15:0];
    end
  end
  // run lengths of the low and high levels on the transmit pin
  always_ff @(posedge clk) begin
    if (srst || tx) begin
      lo_q <= 32'h0;
    end else begin
      lo_q <= lo_q + 32'h1;
    end
  end
  always_ff @(posedge clk) begin
    if (srst || !tx) begin
      hi_q <= 32'h0;
    end else begin
      hi_q <= hi_q + 32'h1;
    end
  end
  // a low run above nine bits can only be a break; the next low is the sync start bit
  always_ff @(posedge clk) begin
    if (srst) begin
      brk_q <= 1'b0;
      syn_q <= 1'b0;
    end else begin
      brk_q <= tx ? (brk_q || lo_q > 9 * div) : 1'b0;
      syn_q <= tx ? 1'b0 : (syn_q || brk_q);
    end
  end
  sequence s_acc;
    psel && penable;
  endsequence
  sequence s_bad;
    paddr > lmfe_pkg::OFS_STATUS || paddr[1:0] != 2'h0;
  endsequence
  property p_ready; s_acc |-> pready; endproperty
  a_ready: assert property (p_ready) else $error("access without ready");
  property p_err_bad; s_acc ##0 s_bad |-> pslverr; endproperty
  a_err_bad: assert property (p_err_bad) else $error("unmapped access not refused");
  property p_err_ok;
    psel && penable && paddr <= lmfe_pkg::OFS_STATUS && paddr[1:0] == 2'h0 |-> !pslverr;
  endproperty
  a_err_ok: assert property (p_err_ok) else $error("mapped access refused");
  property p_err_idle; !(psel && penable) |-> !pslverr; endproperty
  a_err_idle: assert property (p_err_idle) else $error("error outside access");
  property p_rst; $fell(srst) |-> tx && prdata == 32'h0; endproperty
  a_rst: assert property (p_rst) else $error("bus not recessive after reset");
  property p_brk; $rose(tx) && lo_q > 9 * div |-> lo_q == 13 * div; endproperty
  a_brk: assert property (p_brk) else $error("break length wrong");
  property p_delim; $fell(tx) && brk_q |-> hi_q == div; endproperty
  a_delim: assert property (p_delim) else $error("delimiter length wrong");
  property p_sync; $rose(tx) && syn_q |-> lo_q == div; endproperty
  a_sync: assert property (p_sync) else $error("sync start bit wrong");
  property p_lowmax; lo_q <= 13 * div; endproperty
  a_lowmax: assert property (p_lowmax) else $error("dominant run too long");
endmodule : lmfe_sva

bind lmfe_top lmfe_sva u_sva (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .lin_rx(lin_rx), .bus_transmit_output(bus_transmit_output));

// File: lmfe_lin_node.sv
// behavioural lin slave node on the wired-and bus
`timescale 1ns/1ns
module lmfe_lin_node (
  // clock
  input wire logic clk,
  // bus
  input wire logic tx,
  output logic rx
);
  logic drv_q;
  initial drv_q = 1'b1;
  // pull-up bus: recessive unless a party pulls it dominant
  assign rx = tx & drv_q;
  task automatic put_bit(input logic b, input int div);
    drv_q <= b;
    repeat (div) @(posedge clk);
  endtask : put_bit
  task automatic send_byte(input logic [7:0] b, input int div);
    put_bit(1'b0, div);
    for (int i = 0; i < 8; i++) begin
      put_bit(b[i], div);
    end
    put_bit(1'b1, div);
  endtask : send_byte
  task automatic hold_low(input int n);
    put_bit(1'b0, n);
    drv_q <= 1'b1;
  endtask : hold_low
endmodule : lmfe_lin_node

// File: lmfe_top_tb_top.sv
// self-checking testbench for the lin master frame engine
`timescale 1ns/1ns
module lmfe_top_tb_top;
  localparam int DIV = 8;
  logic clk, srst, psel, penable, pwrite, pready, pslverr, lin_rx, tx, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  int failures, tests_run;

  lmfe_top u_dut (.clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .lin_rx(lin_rx), .bus_transmit_output(tx));
  lmfe_lin_node u_node (.clk(clk), .tx(tx), .rx(lin_rx));

  always #20 clk = ~clk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  function automatic logic [7:0] pid_of(input logic [5:0] id);
    return {~(id[1] ^ id[3] ^ id[4] ^ id[5]), id[0] ^ id[1] ^ id[2] ^ id[4], id};
  endfunction : pid_of

  function automatic logic [7:0] csum(input logic [7:0] q[$], input int s);
    foreach (q[i]) begin
      s = s + q[i];
      if (s > 255) s = s - 255;
    end
    return ~s[7:0];
  endfunction : csum

  task automatic run_len(input logic lvl, input int lim, output int n);
    n = 0;
    while (tx === lvl && n < lim) begin
      @(posedge clk);
      n++;
    end
  endtask : run_len

  // samples each bit in its middle, the way a listening slave would
  task automatic get_byte(output logic [7:0] b);
    int n;
    run_len(1'b1, 4000, n);
    repeat (DIV / 2) @(posedge clk);
    chk(tx, 1'b0);
    for (int i = 0; i < 8; i++) begin
      repeat (DIV) @(posedge clk);
      b[i] = tx;
    end
    repeat (DIV) @(posedge clk);
    chk(tx, 1'b1);
  endtask : get_byte

  task automatic frame(input logic [5:0] id, input int n, input bit pub, input bit enh,
                       input bit bad);
    logic [7:0] d[$];
    logic [63:0] pl, msk;
    logic [7:0] b, cs;
    int k;
    pl = {$urandom, $urandom};
    msk = 64'h0;
    for (int i = 0; i < n; i++) begin
      d.push_back(pl[8 * i +: 8]);
      msk[8 * i +: 8] = 8'hFF;
    end
    cs = csum(d, enh ? pid_of(id) : 0);
    apb(1'b1, lmfe_pkg::OFS_PAYLOAD_LO, pl[31:0]);
    apb(1'b1, lmfe_pkg::OFS_PAYLOAD_HI, pl[63:32]);
    apb(1'b1, lmfe_pkg::OFS_BUF_ID, (n - 1) << 10 | enh << 9 | pub << 8 | id);
    apb(1'b1, lmfe_pkg::OFS_CONTROL_TWO, 32'h1);
    run_len(1'b1, 200, k);
    run_len(1'b0, 400, k);
    chk(k, 13 * DIV);
    run_len(1'b1, 400, k);
    chk(k, DIV);
    get_byte(b);
    chk(b, lmfe_pkg::SYNC_BYTE);
    get_byte(b);
    chk(b, pid_of(id));
    if (pub) begin
      foreach (d[i]) begin
        get_byte(b);
        chk(b, d[i]);
      end
      get_byte(b);
      chk(b, cs);
    end else begin
      // response space lets the engine see a clean falling edge
      repeat (DIV) @(posedge clk);
      apb(1'b1, lmfe_pkg::OFS_PAYLOAD_LO, 32'h0);
      apb(1'b1, lmfe_pkg::OFS_PAYLOAD_HI, 32'h0);
      foreach (d[i]) u_node.send_byte(d[i], DIV);
      u_node.send_byte(bad ? ~cs : cs, DIV);
    end
    repeat (2 * DIV) @(posedge clk);
    apb(1'b0, lmfe_pkg::OFS_STATUS, 32'h0);
    chk(r[2:0], pub ? 3'h1 : bad ? 3'h4 : 3'h2);
    if (!pub && !bad) begin
      apb(1'b0, lmfe_pkg::OFS_PAYLOAD_LO, 32'h0);
      chk(r & msk[31:0], pl[31:0] & msk[31:0]);
      apb(1'b0, lmfe_pkg::OFS_PAYLOAD_HI, 32'h0);
      chk(r & msk[63:32], pl[63:32] & msk[63:32]);
    end
    apb(1'b1, lmfe_pkg::OFS_STATUS, 32'h1F);
    $display("test frame id=%h len=%0d pub=%0d enh=%0d done", id, n, pub, enh);
  endtask : frame

  task automatic end_sim();
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_sim

  initial begin
    repeat (60000) @(posedge clk);
    failures++;
    end_sim();
  end

  initial begin
    int n;
    clk = 1'b0;
    srst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    failures = 0;
    tests_run = 0;
    void'($urandom(89));
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    apb(1'b0, lmfe_pkg::OFS_CONTROL_ONE, 32'h0);
    chk(r, 32'h2);
    apb(1'b0, lmfe_pkg::OFS_STATUS, 32'h0);
    chk(r[11:10], 2'h0);
    apb(1'b1, lmfe_pkg::OFS_CONTROL_ONE, 32'h9);
    apb(1'b1, lmfe_pkg::OFS_BAUD, DIV);
    apb(1'b0, lmfe_pkg::OFS_STATUS, 32'h0);
    chk(r[11:10], 2'h1);
    apb(1'b0, 8'h40, 32'h0);
    chk(err, 1'b1);
    apb(1'b1, lmfe_pkg::OFS_CONTROL_ONE, 32'h8);
    apb(1'b1, lmfe_pkg::OFS_BAUD, 32'h20);
    apb(1'b0, lmfe_pkg::OFS_BAUD, 32'h0);
    chk(r, DIV);
    apb(1'b0, lmfe_pkg::OFS_STATUS, 32'h0);
    chk(r[11:10], 2'h2);
    $display("test modes done");
    for (int m = 0; m < 6; m++) begin
      frame($urandom % 64, m == 0 ? 1 : m == 4 ? 8 : 1 + $urandom % 8, m % 2 == 0, m / 2 == 1,
            m == 5);
    end
    // entering init mid-break must silence the bus at once
    apb(1'b1, lmfe_pkg::OFS_CONTROL_TWO, 32'h1);
    run_len(1'b1, 200, n);
    apb(1'b1, lmfe_pkg::OFS_CONTROL_ONE, 32'h9);
    repeat (2) @(posedge clk);
    run_len(1'b1, 300, n);
    chk(n, 300);
    apb(1'b1, lmfe_pkg::OFS_CONTROL_ONE, 32'h0);
    apb(1'b1, lmfe_pkg::OFS_CONTROL_TWO, 32'h1);
    run_len(1'b1, 300, n);
    chk(n, 300);
    apb(1'b0, lmfe_pkg::OFS_CONTROL_TWO, 32'h0);
    chk(r[0], 1'b1);
    $display("test abort and slave done");
    for (int aw = 0; aw < 2; aw++) begin
      apb(1'b1, lmfe_pkg::OFS_CONTROL_ONE, 32'h2 | aw << 2);
      u_node.hold_low(lmfe_pkg::WAKE_CYCLES + 20);
      apb(1'b0, lmfe_pkg::OFS_CONTROL_ONE, 32'h0);
      chk(r[2:0], aw ? 3'h4 : 3'h2);
      apb(1'b0, lmfe_pkg::OFS_STATUS, 32'h0);
      chk(r[4], 1'b1);
      apb(1'b1, lmfe_pkg::OFS_STATUS, 32'h1F);
      $display("test wake auto=%0d done", aw);
    end
    end_sim();
  end
endmodule : lmfe_top_tb_top
